// ---- logic/prld_regs.vh ----
// constants shared by the power-up resource loader and its key matcher
`ifndef PRLD_REGS_VH
`define PRLD_REGS_VH
// ----------------------------------------------------------------
// image layout
// ----------------------------------------------------------------
`define PRLD_SIG0 8'h55
`define PRLD_SIG1 8'hbb
`define PRLD_HDR_BYTES 10'h004
`define PRLD_RES_MAX 10'h180
`define PRLD_PATCH_BYTES 10'h17e
`define PRLD_RAM_DEPTH 766
`define PRLD_HW_CFG_BYTES 10'h013
`define PRLD_PNP_ID_BYTES 10'h009
`define PRLD_VER_BYTES 10'h003
// ----------------------------------------------------------------
// host command values
// ----------------------------------------------------------------
`define PRLD_DIS_STD_KEY 8'h55
`define PRLD_DIS_VND_KEY 8'h56
`define PRLD_KEY_LEN 6'h20
`define PRLD_CFG_PORT_DEFAULT 12'h279
// ----------------------------------------------------------------
// codec playback dma mode: width 8, count by byte, type a
// ----------------------------------------------------------------
`define PRLD_DMA_MODE 3'h1
`define PRLD_DEFAULT_FILL 8'h00
`endif

// ---- logic/prld_key_match.v ----
// byte-serial matcher for the 32-byte vendor unlock key
`timescale 1ns/100ps
`include "prld_regs.vh"
module prld_key_match (
   // clock and reset
   input wire clock,
   input wire rst_n,
   // written bytes
   input wire enable,
   input wire wr,
   input wire [7:0] data,
   // result
   output reg hit_r
);
   reg [5:0] idx_r;

   // ----------------------------------------------------------------
   // key table
   // ----------------------------------------------------------------
   function [7:0] prld_key_byte;
      input [4:0] i;
      begin
         case (i)
            5'h00: prld_key_byte = 8'h96;
            5'h01: prld_key_byte = 8'h35;
            5'h02: prld_key_byte = 8'h9a;
            5'h03: prld_key_byte = 8'hcd;
            5'h04: prld_key_byte = 8'he6;
            5'h05: prld_key_byte = 8'hf3;
            5'h06: prld_key_byte = 8'h79;
            5'h07: prld_key_byte = 8'hbc;
            5'h08: prld_key_byte = 8'h5e;
            5'h09: prld_key_byte = 8'haf;
            5'h0a: prld_key_byte = 8'h57;
            5'h0b: prld_key_byte = 8'h2b;
            5'h0c: prld_key_byte = 8'h15;
            5'h0d: prld_key_byte = 8'h8a;
            5'h0e: prld_key_byte = 8'hc5;
            5'h0f: prld_key_byte = 8'he2;
            5'h10: prld_key_byte = 8'hf1;
            5'h11: prld_key_byte = 8'hf8;
            5'h12: prld_key_byte = 8'h7c;
            5'h13: prld_key_byte = 8'h3e;
            5'h14: prld_key_byte = 8'h9f;
            5'h15: prld_key_byte = 8'h4f;
            5'h16: prld_key_byte = 8'h27;
            5'h17: prld_key_byte = 8'h13;
            5'h18: prld_key_byte = 8'h09;
            5'h19: prld_key_byte = 8'h84;
            5'h1a: prld_key_byte = 8'h42;
            5'h1b: prld_key_byte = 8'ha1;
            5'h1c: prld_key_byte = 8'hd0;
            5'h1d: prld_key_byte = 8'h68;
            5'h1e: prld_key_byte = 8'h34;
            default: prld_key_byte = 8'h1a;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // matching
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idx_r <= 6'h00;
         hit_r <= 1'b0;
      end else begin
         hit_r <= 1'b0;
         if (!enable) begin
            idx_r <= 6'h00;
         end else if (wr) begin
            if (data == prld_key_byte(idx_r[4:0])) begin
               if (idx_r == `PRLD_KEY_LEN - 6'h01) begin
                  idx_r <= 6'h00;
                  hit_r <= 1'b1;
               end else begin
                  idx_r <= idx_r + 6'h01;
               end
            end else if (data == prld_key_byte(5'h00)) begin
               idx_r <= 6'h01;
            end else begin
               idx_r <= 6'h00;
            end
         end
      end
   end
endmodule

// ---- logic/prld_top.v ----
// power-up resource loader with vendor key detection
`timescale 1ns/100ps
`include "prld_regs.vh"
module prld_top (
   // clock and isa reset
   input wire clock,
   input wire rst_n,
   // byte reads from the serial memory engine
   output reg mem_rd_req_r,
   output reg [9:0] mem_addr_r,
   input wire mem_rd_ack,
   input wire [7:0] mem_rd_data,
   // host writes, already decoded
   input wire cfg_port_wr,
   input wire [7:0] cfg_port_data,
   input wire ctrl5_wr,
   input wire [7:0] ctrl5_data,
   // host download of resource data
   input wire dl_restart,
   input wire dl_wr,
   input wire [7:0] dl_data,
   // ram read port for the configuration logic and processor
   input wire [9:0] ram_rd_addr,
   output reg [7:0] ram_rd_data_r,
   // status
   output reg load_done_r,
   output reg mem_present_r,
   output reg [9:0] res_len_r,
   output reg config_mode_r,
   output reg std_key_dis_r,
   output reg vnd_key_dis_r,
   output reg direct_wr_r,
   output reg [7:0] direct_data_r,
   output reg [2:0] codec_dma_mode_r
);
   localparam ST_START = 3'h0;
   localparam ST_SIG0 = 3'h1;
   localparam ST_SIG1 = 3'h2;
   localparam ST_LENH = 3'h3;
   localparam ST_LENL = 3'h4;
   localparam ST_COPY = 3'h5;
   localparam ST_DONE = 3'h6;

   reg [7:0] ram [0:`PRLD_RAM_DEPTH-1];
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [9:0] count_r;
   reg [9:0] total_r;
   reg [9:0] wptr_r;
   reg ram_loaded_r;
   reg ram_we;
   reg [9:0] ram_waddr;
   reg [7:0] ram_wdata;
   wire key_hit;
   wire [9:0] len_clip;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [9:0] prld_clip_len;
      input [15:0] len;
      begin
         if (len > {6'h00, `PRLD_RES_MAX})
            prld_clip_len = `PRLD_RES_MAX;
         else
            prld_clip_len = len[9:0];
      end
   endfunction

   // length field arrives high byte first
   assign len_clip = prld_clip_len({res_len_r[7:0], mem_rd_data});

   // ----------------------------------------------------------------
   // loader sequence
   // ----------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_START: state_nxt = ST_SIG0;
         ST_SIG0: begin
            if (mem_rd_ack) begin
               if (mem_rd_data == `PRLD_SIG0)
                  state_nxt = ST_SIG1;
               else
                  state_nxt = ST_DONE;
            end
         end
         ST_SIG1: begin
            if (mem_rd_ack) begin
               if (mem_rd_data == `PRLD_SIG1)
                  state_nxt = ST_LENH;
               else
                  state_nxt = ST_DONE;
            end
         end
         ST_LENH: begin
            if (mem_rd_ack)
               state_nxt = ST_LENL;
         end
         ST_LENL: begin
            if (mem_rd_ack)
               state_nxt = ST_COPY;
         end
         ST_COPY: begin
            if (mem_rd_ack && count_r == total_r - 10'h001)
               state_nxt = ST_DONE;
         end
         ST_DONE: state_nxt = ST_DONE;
         default: state_nxt = ST_START;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_START;
         mem_rd_req_r <= 1'b0;
         mem_addr_r <= 10'h000;
         count_r <= 10'h000;
         total_r <= 10'h000;
         res_len_r <= 10'h000;
         mem_present_r <= 1'b0;
         load_done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         case (state_r)
            ST_START: begin
               mem_rd_req_r <= 1'b1;
               mem_addr_r <= 10'h000;
            end
            ST_SIG0, ST_SIG1, ST_LENH: begin
               if (mem_rd_ack) begin
                  mem_addr_r <= mem_addr_r + 10'h001;
                  mem_rd_req_r <= (state_nxt != ST_DONE);
                  if (state_r == ST_LENH)
                     res_len_r <= {2'h0, mem_rd_data};
               end
            end
            ST_LENL: begin
               if (mem_rd_ack) begin
                  // header done; next fetch is the image byte at address 4
                  mem_addr_r <= `PRLD_HDR_BYTES;
                  res_len_r <= len_clip;
                  total_r <= len_clip + `PRLD_PATCH_BYTES;
                  count_r <= 10'h000;
                  mem_present_r <= 1'b1;
               end
            end
            ST_COPY: begin
               if (mem_rd_ack) begin
                  count_r <= count_r + 10'h001;
                  mem_addr_r <= mem_addr_r + 10'h001;
                  if (state_nxt == ST_DONE)
                     mem_rd_req_r <= 1'b0;
               end
            end
            ST_DONE: begin
               mem_rd_req_r <= 1'b0;
               load_done_r <= 1'b1;
            end
            default: mem_rd_req_r <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // ram writes: power-up copy or host download
   // ----------------------------------------------------------------
   always @* begin
      ram_we = 1'b0;
      ram_waddr = count_r;
      ram_wdata = mem_rd_data;
      if (state_r == ST_COPY && mem_rd_ack) begin
         // config, id, version, text, devices 0-4, end tag, then patch
         ram_we = 1'b1;
      end else if (load_done_r && !mem_present_r && dl_wr &&
                   wptr_r < `PRLD_RES_MAX) begin
         ram_we = 1'b1;
         ram_waddr = wptr_r;
         ram_wdata = dl_data;
      end
   end

   always @(posedge clock) begin
      if (ram_we)
         ram[ram_waddr] <= ram_wdata;
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= 10'h000;
         ram_loaded_r <= 1'b0;
      end else begin
         if (state_r == ST_COPY && mem_rd_ack) begin
            ram_loaded_r <= 1'b1;
         end else if (load_done_r && !mem_present_r) begin
            if (dl_restart) begin
               wptr_r <= 10'h000;
            end else if (ram_we) begin
               wptr_r <= wptr_r + 10'h001;
               ram_loaded_r <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // ram read: built-in defaults until something was loaded
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ram_rd_data_r <= 8'h00;
      end else if (ram_rd_addr >= `PRLD_RAM_DEPTH) begin
         ram_rd_data_r <= 8'h00;
      end else if (ram_loaded_r) begin
         ram_rd_data_r <= ram[ram_rd_addr];
      end else begin
         ram_rd_data_r <= `PRLD_DEFAULT_FILL;
      end
   end

   // ----------------------------------------------------------------
   // key detection and direct configuration
   // ----------------------------------------------------------------
   prld_key_match u_key (
      .clock(clock),
      .rst_n(rst_n),
      .enable(load_done_r & ~vnd_key_dis_r),
      .wr(cfg_port_wr),
      .data(cfg_port_data),
      .hit_r(key_hit)
   );

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         config_mode_r <= 1'b0;
         std_key_dis_r <= 1'b0;
         vnd_key_dis_r <= 1'b0;
         direct_wr_r <= 1'b0;
         direct_data_r <= 8'h00;
         codec_dma_mode_r <= 3'h0;
      end else begin
         codec_dma_mode_r <= `PRLD_DMA_MODE;
         direct_wr_r <= config_mode_r & cfg_port_wr;
         if (cfg_port_wr)
            direct_data_r <= cfg_port_data;
         if (key_hit)
            config_mode_r <= 1'b1;
         if (ctrl5_wr && ctrl5_data == `PRLD_DIS_STD_KEY)
            std_key_dis_r <= 1'b1;
         if (ctrl5_wr && ctrl5_data == `PRLD_DIS_VND_KEY)
            vnd_key_dis_r <= 1'b1;
      end
   end
endmodule

// ---- dv/prld_mem_model.sv ----
// serial memory partner answering byte reads of the loader
`timescale 1ns/100ps
module prld_mem_model (
   // clock and reset
   input wire clock,
   input wire rst_n,
   // byte read link
   input wire mem_rd_req_r,
   input wire [9:0] mem_addr_r,
   output reg mem_rd_ack,
   output reg [7:0] mem_rd_data
);
   // image room beyond 770 bytes so patch code fits
   reg [7:0] img [0:1023];
   integer lat = 0;
   integer wait_cnt = 0;
   integer taken = 0;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_ack <= 1'b0;
         mem_rd_data <= 8'h00;
         wait_cnt <= 0;
         taken <= 0;
      end else begin
         if (mem_rd_req_r && mem_rd_ack) begin
            taken <= taken + 1;
         end
         // bytes leave in image order: header, config, id, version, text, devices, end tag, patch
         if (mem_rd_req_r && wait_cnt >= lat) begin
            mem_rd_ack <= 1'b1;
            mem_rd_data <= img[mem_rd_ack ? mem_addr_r + 10'h001 : mem_addr_r];
            wait_cnt <= 0;
         end else begin
            // released data line toggles instead of holding the last byte
            mem_rd_ack <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
            wait_cnt <= mem_rd_req_r ? wait_cnt + 1 : 0;
         end
      end
   end
endmodule

// ---- dv/prld_props.sv ----
// port assertions for the power-up loader and key matcher
`timescale 1ns/100ps
module prld_props (
   // clock and reset
   input wire clock,
   input wire rst_n,
   // memory link
   input wire mem_rd_req_r,
   input wire [9:0] mem_addr_r,
   input wire mem_rd_ack,
   input wire [7:0] mem_rd_data,
   // host writes
   input wire cfg_port_wr,
   input wire [7:0] cfg_port_data,
   input wire ctrl5_wr,
   input wire [7:0] ctrl5_data,
   // status
   input wire load_done_r,
   input wire mem_present_r,
   input wire config_mode_r,
   input wire std_key_dis_r,
   input wire vnd_key_dis_r,
   input wire direct_wr_r,
   input wire [7:0] direct_data_r,
   input wire [2:0] codec_dma_mode_r
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire take = mem_rd_req_r && mem_rd_ack;
   sequence sig_bad;
      take && ((mem_addr_r == 10'h000 && mem_rd_data != 8'h55) ||
         (mem_addr_r == 10'h001 && mem_rd_data != 8'hbb));
   endsequence
   sequence absent_seen;
      !mem_rd_req_r ##1 (load_done_r && !mem_present_r);
   endsequence
   a_sig_abort: assert property (sig_bad |=> absent_seen)
      else $error("signature mismatch did not end the load");
   a_sig_accept: assert property (take && mem_addr_r == 10'h000 &&
      mem_rd_data == 8'h55 |=> mem_rd_req_r && mem_addr_r == 10'h001)
      else $error("first signature byte not followed by second read");
   a_len_advance: assert property (take && mem_addr_r inside {10'h002,
      10'h003} |=> mem_rd_req_r && mem_addr_r == $past(mem_addr_r) + 1)
      else $error("length bytes not read in turn");
   a_present_addr: assert property ($rose(mem_present_r) |->
      mem_addr_r == 10'h004 && mem_rd_req_r)
      else $error("memory present flagged away from header end");
   a_done_idle: assert property (load_done_r |-> !mem_rd_req_r)
      else $error("memory read still wanted after load done");
   a_dma_mode: assert property (rst_n |=> codec_dma_mode_r == 3'h1)
      else $error("codec playback dma mode wrong");
   a_std_disable: assert property (ctrl5_wr && ctrl5_data == 8'h55
      |=> std_key_dis_r)
      else $error("standard key not disabled");
   a_vnd_disable: assert property (ctrl5_wr && ctrl5_data == 8'h56
      |=> vnd_key_dis_r [*4])
      else $error("vendor key disable not held");
   a_key_locked: assert property ((vnd_key_dis_r && !config_mode_r) [*3]
      |=> !config_mode_r)
      else $error("config mode entered with vendor key disabled");
   a_early_key: assert property (!load_done_r |-> !config_mode_r)
      else $error("config mode entered before load done");
   a_key_result: assert property ($rose(config_mode_r) |->
      $past(cfg_port_wr, 2) && $past(cfg_port_data, 2) == 8'h1a)
      else $error("config mode not two cycles after last key byte");
   a_direct_pulse: assert property (config_mode_r && cfg_port_wr |=>
      direct_wr_r && direct_data_r == $past(cfg_port_data))
      else $error("config mode write not forwarded");
   a_no_direct: assert property (!config_mode_r |=> !direct_wr_r)
      else $error("write forwarded outside config mode");
endmodule
bind prld_top prld_props u_props (.clock(clock), .rst_n(rst_n),
   .mem_rd_req_r(mem_rd_req_r), .mem_addr_r(mem_addr_r),
   .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
   .cfg_port_wr(cfg_port_wr), .cfg_port_data(cfg_port_data),
   .ctrl5_wr(ctrl5_wr), .ctrl5_data(ctrl5_data),
   .load_done_r(load_done_r), .mem_present_r(mem_present_r),
   .config_mode_r(config_mode_r), .std_key_dis_r(std_key_dis_r),
   .vnd_key_dis_r(vnd_key_dis_r), .direct_wr_r(direct_wr_r),
   .direct_data_r(direct_data_r), .codec_dma_mode_r(codec_dma_mode_r));

// ---- dv/prld_top_tb.sv ----
// self-checking bench for the power-up loader and key matcher
`timescale 1ns/100ps
module prld_top_tb;
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   wire mem_rd_req_r, mem_rd_ack, load_done_r, mem_present_r;
   wire config_mode_r, std_key_dis_r, vnd_key_dis_r, direct_wr_r;
   wire [9:0] mem_addr_r, res_len_r;
   wire [7:0] mem_rd_data, ram_rd_data_r, direct_data_r;
   wire [2:0] codec_dma_mode_r;
   reg cfg_port_wr = 1'b0, ctrl5_wr = 1'b0;
   reg dl_restart = 1'b0, dl_wr = 1'b0;
   reg [7:0] cfg_port_data = 8'h00, ctrl5_data = 8'h00, dl_data = 8'h00;
   reg [9:0] ram_rd_addr = 10'h000;
   reg [7:0] v;
   integer err_count = 0, cmp_count = 0, i;
   localparam [255:0] KEY = {128'h96359acde6f379bc5eaf572b158ac5e2,
      128'hf1f87c3e9f4f2713098442a1d068341a};
   prld_top dut (.clock(clock), .rst_n(rst_n), .mem_rd_req_r(mem_rd_req_r),
      .mem_addr_r(mem_addr_r), .mem_rd_ack(mem_rd_ack),
      .mem_rd_data(mem_rd_data), .cfg_port_wr(cfg_port_wr),
      .cfg_port_data(cfg_port_data),
      .ctrl5_wr(ctrl5_wr), .ctrl5_data(ctrl5_data), .dl_restart(dl_restart),
      .dl_wr(dl_wr), .dl_data(dl_data), .ram_rd_addr(ram_rd_addr),
      .ram_rd_data_r(ram_rd_data_r), .load_done_r(load_done_r),
      .mem_present_r(mem_present_r), .res_len_r(res_len_r),
      .config_mode_r(config_mode_r), .std_key_dis_r(std_key_dis_r),
      .vnd_key_dis_r(vnd_key_dis_r), .direct_wr_r(direct_wr_r),
      .direct_data_r(direct_data_r), .codec_dma_mode_r(codec_dma_mode_r));
   prld_mem_model mem (.clock(clock), .rst_n(rst_n),
      .mem_rd_req_r(mem_rd_req_r), .mem_addr_r(mem_addr_r),
      .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));
   always #25 clock = ~clock;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task give_verdict;
      $display("mismatches %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task do_reset;
      @(negedge clock) rst_n = 1'b0;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
   endtask
   task wait_done;
      integer n;
      n = 0;
      while (load_done_r !== 1'b1 && n < 4000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 4000) begin
         err_count++;
         $display("MISMATCH load_done expected 1 seen %b", load_done_r);
         give_verdict;
      end
   endtask
   task send_key(input integer first, count);
      integer k;
      for (k = first; k < first + count; k++) begin
         @(negedge clock) cfg_port_wr = 1'b1;
         cfg_port_data = KEY[255 - 8 * k -: 8];
      end
      @(negedge clock) cfg_port_wr = 1'b0;
   endtask
   task port_put(input [7:0] b);
      @(negedge clock) cfg_port_wr = 1'b1;
      cfg_port_data = b;
      @(negedge clock) cfg_port_wr = 1'b0;
   endtask
   task c5(input [7:0] b);
      @(negedge clock) ctrl5_wr = 1'b1;
      ctrl5_data = b;
      @(negedge clock) ctrl5_wr = 1'b0;
   endtask
   task ram_at(input [9:0] a);
      @(negedge clock) ram_rd_addr = a;
      @(negedge clock) v = ram_rd_data_r;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_absent(input [7:0] b0, b1, input integer exp_taken);
      mem.img[0] = b0;
      mem.img[1] = b1;
      do_reset;
      wait_done;
      chk("present", 16'h0000, 16'(mem_present_r));
      chk("bytes read", 16'(exp_taken), 16'(mem.taken));
      ram_at(10'h000);
      chk("default fill", 16'h0000, 16'(v));
      // a stray byte first, so that the restart has to move the pointer back
      @(negedge clock) dl_wr = 1'b1;
      dl_data = 8'hff;
      @(negedge clock) dl_wr = 1'b0;
      dl_restart = 1'b1;
      @(negedge clock) dl_restart = 1'b0;
      for (i = 0; i < 3; i++) begin
         @(negedge clock) dl_wr = 1'b1;
         dl_data = 8'ha0 + 8'(i);
      end
      @(negedge clock) dl_wr = 1'b0;
      for (i = 0; i < 3; i++) begin
         ram_at(10'(i));
         chk("download", 16'(8'ha0 + 8'(i)), 16'(v));
      end
   endtask
   task t_load(input [15:0] len, input integer lat);
      integer n, pe;
      n = len > 384 ? 384 : len;
      // under the clip the byte past the end still holds the earlier
      // image of length 200h, whose bytes are their own address
      pe = n < 384 ? (n + 386) % 256 : 0;
      mem.lat = lat;
      mem.img[0] = 8'h55;
      mem.img[1] = 8'hbb;
      mem.img[2] = len[15:8];
      mem.img[3] = len[7:0];
      for (i = 4; i < 1024; i++) mem.img[i] = 8'(i) ^ len[7:0];
      do_reset;
      send_key(0, 32);
      repeat (2) @(negedge clock);
      chk("early key", 16'h0000, 16'(config_mode_r));
      wait_done;
      chk("present", 16'h0001, 16'(mem_present_r));
      chk("length", 16'(n), 16'(res_len_r));
      chk("bytes read", 16'(n + 386), 16'(mem.taken));
      chk("dma mode", 16'h0001, 16'(codec_dma_mode_r));
      ram_at(10'h000);
      chk("first byte", 16'(mem.img[4]), 16'(v));
      ram_at(10'(n + 381));
      chk("last patch", 16'(mem.img[n + 385]), 16'(v));
      ram_at(10'(n + 382));
      chk("past end", 16'(pe), 16'(v));
   endtask
   task t_key;
      mem.img[0] = 8'h00;
      do_reset;
      wait_done;
      send_key(0, 9);
      port_put(8'h00);
      send_key(9, 23);
      repeat (3) @(negedge clock);
      chk("broken key", 16'h0000, 16'(config_mode_r));
      send_key(0, 5);
      port_put(8'h96);
      send_key(1, 31);
      repeat (2) @(negedge clock);
      chk("key", 16'h0001, 16'(config_mode_r));
      port_put(8'h06);
      chk("direct wr", 16'h0001, 16'(direct_wr_r));
      chk("direct data", 16'h0006, 16'(direct_data_r));
   endtask
   task t_dis;
      do_reset;
      wait_done;
      c5(8'h55);
      chk("std dis", 16'h0001, 16'(std_key_dis_r));
      chk("vnd dis", 16'h0000, 16'(vnd_key_dis_r));
      c5(8'h56);
      chk("vnd dis", 16'h0001, 16'(vnd_key_dis_r));
      send_key(0, 32);
      repeat (3) @(negedge clock);
      chk("locked key", 16'h0000, 16'(config_mode_r));
      do_reset;
      chk("std clear", 16'h0000, 16'(std_key_dis_r));
      chk("vnd clear", 16'h0000, 16'(vnd_key_dis_r));
   endtask
   initial begin
      t_absent(8'h12, 8'hbb, 1);
      t_absent(8'h55, 8'h12, 2);
      t_load(16'h0200, 2);
      t_load(16'h00dd, 0);
      t_key;
      t_dis;
      give_verdict;
   end
endmodule
